// file: hw/bgsv_pkg.sv
// Constants for the buck gate sequencer and charge-voltage decoder.
// Assumes a single 40 MHz reference clock and a plain strobe register port.
package bgsv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ        = 40_000_000;  // Reference clock rate
  localparam int FSW_HI_HZ     = 500_000;     // Fast switching rate
  localparam int FSW_LO_HZ     = 300_000;     // Default switching rate
  localparam int DEAD_NS       = 50;          // Break-before-make gap
  localparam int RECHARGE_NS   = 80;          // Low-side recharge pulse
  // Longest period rounds down, least times round up
  localparam int PER_HI_CYC    = CLK_HZ / FSW_HI_HZ;
  localparam int PER_LO_CYC    = CLK_HZ / FSW_LO_HZ;
  localparam int DEAD_CYC      = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int RECH_CYC      = (RECHARGE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BST_LOW_LIMIT = 3;           // Low cycles tolerated

  localparam logic [7:0] PER_HI_LAST = 8'(PER_HI_CYC - 1);
  localparam logic [7:0] PER_LO_LAST = 8'(PER_LO_CYC - 1);
  localparam logic [7:0] DEAD_LAST   = 8'(DEAD_CYC - 1);
  localparam logic [7:0] RECH_LAST   = 8'(RECH_CYC - 1);
  localparam logic [1:0] BST_LIM     = 2'(BST_LOW_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // Register map (8-bit address, 16-bit data)
  localparam logic [7:0]  ADDR_MODE   = 8'h12;    // Charger mode
  localparam logic [7:0]  ADDR_STATUS = 8'h13;    // Charger status
  localparam logic [7:0]  ADDR_VREG   = 8'h15;    // Charge voltage, mV
  localparam logic [15:0] MODE_RST    = 16'h0001; // Charge ended, 300 kHz
  localparam logic [15:0] VREG_RST    = 16'h0000; // Invalid until written
  localparam int          MODE_END_B  = 0;        // End charge bit
  localparam int          MODE_FS_B   = 5;        // Switching freq select
  localparam int          ST_DIS_B    = 0;        // Converter disabled
  localparam int          ST_SYNC_B   = 2;        // Synchronous mode
  localparam int          ST_RFSH_B   = 3;        // Bootstrap refresh seen
  localparam int          ST_VOR_B    = 8;        // Voltage out of range

  ////////////////////////////////////////////////////////////////////////////
  // Charge voltage decode, all in mV
  localparam logic [15:0] V_WAKE     = 16'h2328;  // 9000
  localparam logic [15:0] V_3C_LO    = 16'h2EE0;  // 12000
  localparam logic [15:0] V_3C_HI    = 16'h3840;  // 14400
  localparam logic [15:0] V_4C_LO    = 16'h3E80;  // 16000
  localparam logic [15:0] V_4C_HI    = 16'h4B00;  // 19200
  localparam logic [16:0] STEP_3C_Q4 = 17'h0004B; // 18.75 mV times 4
  localparam logic [16:0] STEP_4C    = 17'h00019; // 25 mV
  localparam logic [6:0]  CODE_MAX   = 7'h7F;     // 127 of 128 steps
  localparam logic [2:0]  CELLS_2    = 3'h2;
  localparam logic [2:0]  CELLS_3    = 3'h3;
  localparam logic [2:0]  CELLS_4    = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Gate sequencer states
  typedef enum logic [5:0] {
    ST_OFF   = 6'h01,  // Converter disabled, both off
    ST_HS    = 6'h02,  // High side on
    ST_DEADF = 6'h04,  // Gap after high side off
    ST_LS    = 6'h08,  // Low side on
    ST_DEADR = 6'h10,  // Gap before high side on
    ST_IDLE  = 6'h20   // Both off until next cycle
  } bgsv_state_t;

endpackage

// file: hw/bgsv_top.sv
// Gate sequencer for a synchronous buck charger plus charge-voltage decode.
// Assumes comparator inputs arrive asynchronously from the analog side and
// that the register master follows the one-cycle strobe protocol.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module bgsv_top
  import bgsv_pkg::*;
(
  input  wire logic        ref_clk_i,        // 40 MHz reference clock
  input  wire logic        rst_i,            // Synchronous reset, high
  input  wire logic        ce_i,             // Clock enable, low freezes
  input  wire logic [7:0]  reg_addr_i,       // Register address
  input  wire logic [15:0] reg_wdata_i,      // Write data
  input  wire logic        reg_wr_i,         // Write strobe
  input  wire logic        reg_rd_i,         // Read strobe
  output logic      [15:0] reg_rdata_o,      // Read data, cycle after
  input  wire logic        error_amp_above_i, // Error amp output above ramp
  input  wire logic        sync_current_above_i, // Current above sync set
  input  wire logic        bootstrap_low_i,  // Bootstrap supply under 4.5 V
  output logic             hs_gate_o,        // High-side gate drive
  output logic             ls_gate_o,        // Low-side gate drive
  output logic             ramp_reset_o,     // Cycle start pulse to ramp
  output logic      [6:0]  cell_code_o,      // Per-cell voltage code
  output logic      [2:0]  cell_count_o,     // Cell count
  output logic             voltage_out_of_range_flag_o // Invalid setting
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three flops, accept when second and third agree
  wire  [2:0] in_f_w;    // Filtered levels, one per input
  wire  [2:0] raw_w = {bootstrap_low_i, sync_current_above_i, error_amp_above_i};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_sync
      logic [2:0] chain_r;  // Three-flop chain, one owner per input
      logic       filt_r;   // Accepted level
      // Shift chain, update filtered copy only on agreement
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          chain_r <= 3'h0;
          filt_r  <= 1'b0;
        end else if (ce_i) begin
          chain_r <= {chain_r[1:0], raw_w[g]};
          if (chain_r[1] == chain_r[2]) begin
            filt_r <= chain_r[2];
          end
        end
      end
      assign in_f_w[g] = filt_r;
    end
  endgenerate

  wire duty_w  = in_f_w[0];  // Duty request level
  wire sync_w  = in_f_w[1];  // Synchronous mode wanted
  wire bstlo_w = in_f_w[2];  // Bootstrap low

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] mode_r;    // Charger mode
  logic [15:0] vreg_r;    // Charge voltage in mV
  logic        rfsh_st_r; // Sticky refresh seen

  wire wr_mode_w = reg_wr_i && (reg_addr_i == ADDR_MODE);
  wire wr_vreg_w = reg_wr_i && (reg_addr_i == ADDR_VREG);
  wire rd_stat_w = reg_rd_i && (reg_addr_i == ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Charge voltage decode
  // Per-cell step decode
  wire [16:0] d3_w    = {1'b0, vreg_r - V_3C_LO} << 2;
  wire [16:0] q3_w    = d3_w / STEP_3C_Q4;
  wire [16:0] q4_w    = {1'b0, vreg_r - V_4C_LO} / STEP_4C;
  wire        is_wake_w = (vreg_r == V_WAKE);
  wire        in_3c_w = (vreg_r >= V_3C_LO) && (vreg_r < V_3C_HI);
  wire        in_4c_w = (vreg_r >= V_4C_LO) && (vreg_r < V_4C_HI);
  wire        over_w  = (vreg_r >= V_4C_HI);
  wire        vor_w   = !(is_wake_w || in_3c_w || in_4c_w);
  // Gaps disable; wake and over still run
  wire        v_ok_w  = is_wake_w || in_3c_w || in_4c_w || over_w;
  wire [6:0]  code_w  = in_3c_w ? q3_w[6:0] :
                        in_4c_w ? q4_w[6:0] :
                        over_w  ? CODE_MAX  : 7'h00;
  // Wake setting counts as two cells
  wire [2:0]  cells_w = is_wake_w ? CELLS_2 :
                        in_3c_w   ? CELLS_3 :
                        (in_4c_w || over_w) ? CELLS_4 : 3'h0;
  wire        en_w    = v_ok_w && !mode_r[MODE_END_B];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and read data
  wire [15:0] status_w = ({15'h0000, !en_w} << ST_DIS_B) |
                         ({15'h0000, sync_w} << ST_SYNC_B) |
                         ({15'h0000, rfsh_st_r} << ST_RFSH_B) |
                         ({15'h0000, vor_w} << ST_VOR_B);
  wire [15:0] rdata_w  = (reg_addr_i == ADDR_MODE)   ? mode_r :
                         (reg_addr_i == ADDR_STATUS) ? status_w :
                         (reg_addr_i == ADDR_VREG)   ? vreg_r : 16'h0000;

  // Register file, read data held only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_r      <= MODE_RST;
      vreg_r      <= VREG_RST;
      reg_rdata_o <= 16'h0000;
    end else if (ce_i) begin
      if (wr_mode_w) begin
        mode_r <= reg_wdata_i;
      end
      if (wr_vreg_w) begin
        vreg_r <= reg_wdata_i;
      end
      reg_rdata_o <= reg_rd_i ? rdata_w : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching period counter
  logic [7:0] per_cnt_r;  // Position in period
  wire  [7:0] per_last_w = mode_r[MODE_FS_B] ? PER_HI_LAST : PER_LO_LAST;
  wire        cyc_end_w  = (per_cnt_r >= per_last_w);

  // Free-running period counter
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      per_cnt_r <= 8'h00;
    end else if (ce_i) begin
      per_cnt_r <= cyc_end_w ? 8'h00 : per_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bootstrap watch
  logic [1:0] bst_cnt_r;  // Consecutive low cycles
  logic       rreq_r;     // Refresh pending

  bgsv_state_t st_r, st_nxt;
  logic [7:0]  t_r;       // Interval timer
  logic        rfsh_r;    // Current low pulse is a refresh
  wire         ls_start_w = (st_nxt == ST_LS) && (st_r != ST_LS);

  // Count low cycles at each boundary, set wins over clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bst_cnt_r <= 2'h0;
      rreq_r    <= 1'b0;
      rfsh_st_r <= 1'b0;
    end else if (ce_i) begin
      if (cyc_end_w && bstlo_w && bst_cnt_r == BST_LIM) begin
        rreq_r    <= 1'b1;
        rfsh_st_r <= 1'b1;
        bst_cnt_r <= 2'h0;
      end else begin
        if (ls_start_w) begin
          rreq_r <= 1'b0;
        end
        if (cyc_end_w) begin
          bst_cnt_r <= bstlo_w ? bst_cnt_r + 2'h1 : 2'h0;
        end
        if (rd_stat_w) begin
          rfsh_st_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate sequencer
  wire dead_done_w = (t_r >= DEAD_LAST);
  wire rech_done_w = (t_r >= RECH_LAST);
  logic rfsh_nxt;

  // Next state
  always_comb begin
    st_nxt   = st_r;
    rfsh_nxt = rfsh_r;
    if (!en_w) begin
      st_nxt   = ST_OFF;
      rfsh_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_OFF, ST_IDLE: begin
          if (cyc_end_w && duty_w) begin
            st_nxt = ST_HS;
          end
        end
        ST_HS: begin
          // Hold on while request stays high and no refresh is pending
          if (!duty_w || rreq_r) begin
            st_nxt   = ST_DEADF;
            rfsh_nxt = rreq_r;
          end
        end
        ST_DEADF: begin
          if (dead_done_w) begin
            st_nxt = ST_LS;
          end
        end
        ST_LS: begin
          if (rfsh_r && rech_done_w) begin
            // Back to full duty after refresh
            st_nxt   = ST_DEADR;
            rfsh_nxt = 1'b0;
          end else if (!rfsh_r && !sync_w && rech_done_w) begin
            st_nxt = ST_IDLE;
          end else if (!rfsh_r && cyc_end_w) begin
            st_nxt = duty_w ? ST_DEADR : ST_IDLE;
          end
        end
        ST_DEADR: begin
          if (dead_done_w) begin
            st_nxt = duty_w ? ST_HS : ST_IDLE;
          end
        end
        default: begin
          st_nxt = ST_OFF;
        end
      endcase
    end
  end

  // State, timer and registered gate outputs
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r         <= ST_OFF;
      t_r          <= 8'h00;
      rfsh_r       <= 1'b0;
      hs_gate_o    <= 1'b0;
      ls_gate_o    <= 1'b0;
      ramp_reset_o <= 1'b0;
    end else if (ce_i) begin
      st_r         <= st_nxt;
      rfsh_r       <= rfsh_nxt;
      t_r          <= (st_nxt != st_r) ? 8'h00 : t_r + 8'h01;
      hs_gate_o    <= (st_nxt == ST_HS);
      ls_gate_o    <= (st_nxt == ST_LS);
      ramp_reset_o <= cyc_end_w;
    end
  end

  // Decode results registered for the analog side
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cell_code_o                 <= 7'h00;
      cell_count_o                <= 3'h0;
      voltage_out_of_range_flag_o <= 1'b0;
    end else if (ce_i) begin
      cell_code_o                 <= code_w;
      cell_count_o                <= cells_w;
      voltage_out_of_range_flag_o <= vor_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] ls_len_h;  // Enabled cycles of low-side on
  logic [7:0] off_len_h; // Enabled cycles of both off
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ls_len_h  <= 8'h00;
      off_len_h <= 8'h00;
    end else if (ce_i) begin
      ls_len_h  <= ls_gate_o ? ls_len_h + 8'h01 : 8'h00;
      off_len_h <= (hs_gate_o || ls_gate_o) ? 8'h00 : off_len_h + 8'h01;
    end
  end

  a_no_overlap: assert property (!(hs_gate_o && ls_gate_o))
    else $error("both gates on");
  a_dead_before_ls: assert property (
    $rose(ls_gate_o) |-> off_len_h >= 8'(DEAD_CYC))
    else $error("low side on without dead time");
  a_dead_before_hs: assert property (
    ($rose(hs_gate_o) && $past(ls_len_h) == 8'h00) |-> $past(!ls_gate_o, 2))
    else $error("high side on right after low side");
  a_pulse_width: assert property (
    (ce_i && ls_gate_o && !rfsh_r && !sync_w) |-> ls_len_h < 8'(RECH_CYC))
    else $error("recharge pulse too long");
  a_disabled_dark: assert property (
    (ce_i && !en_w) |=> (!hs_gate_o && !ls_gate_o))
    else $error("gates active while disabled");
  a_vor_gap: assert property (
    (vreg_r >= V_3C_HI && vreg_r < V_4C_LO) |-> (vor_w && !en_w))
    else $error("gap voltage not rejected");
  a_clamp_top: assert property (
    (ce_i && over_w) |=> (cell_code_o == CODE_MAX && voltage_out_of_range_flag_o))
    else $error("top voltage not clamped");
  a_wake_cells: assert property (
    (ce_i && is_wake_w) |=> (cell_count_o == CELLS_2 && !voltage_out_of_range_flag_o))
    else $error("wake setting misdecoded");
  a_period_sel: assert property (
    (ce_i && cyc_end_w && $stable(per_last_w)) |-> per_cnt_r == per_last_w)
    else $error("period end misplaced");
  a_refresh_req: assert property (
    (ce_i && cyc_end_w && bstlo_w && bst_cnt_r == BST_LIM) |=> rreq_r)
    else $error("refresh not requested");

  c_sync_run: cover property (hs_gate_o ##1 !hs_gate_o [*2] ##1 ls_gate_o [*3]);
  c_refresh: cover property ($rose(rfsh_r) ##[1:20] ls_gate_o);
  c_full_duty: cover property (ramp_reset_o && hs_gate_o);

endmodule

`default_nettype wire

// file: verification/bgsv_drv_model.sv
// Model of the two power switch drivers with a leaky bootstrap capacitor.
// Assumes gate commands arrive on the reference clock of the sequencer.
`timescale 1ns/10ps
`default_nettype none

module bgsv_drv_model (
  input  wire logic clk_i,           // Reference clock
  input  wire logic rst_i,           // Synchronous reset, high
  input  wire logic hs_gate_i,       // High-side command
  input  wire logic ls_gate_i,       // Low-side command
  input  wire logic leak_i,          // Bench lets the bootstrap cap sag
  output logic      bootstrap_low_o, // Bootstrap supply under threshold
  output logic      overlap_o        // Sticky: switches overlapped
);
  logic hs_q;                        // Last high-side command
  logic ls_q;                        // Last low-side command

  ////////////////////////////////////////////////////////////////////////////
  // Cap sags while the high side conducts, any low-side pulse recharges it
  always_ff @(posedge clk_i) begin
    if (rst_i || ls_gate_i) begin
      bootstrap_low_o <= 1'b0;
    end else if (leak_i && hs_gate_i) begin
      bootstrap_low_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // break before make
  // Either switch on together with the other, or right after it
  always_ff @(posedge clk_i) begin
    hs_q <= hs_gate_i;
    ls_q <= ls_gate_i;
    if (rst_i) begin
      overlap_o <= 1'b0;
    end else if ((hs_gate_i && (ls_gate_i || ls_q)) || (ls_gate_i && hs_q)) begin
      overlap_o <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// file: verification/bgsv_top_tb.sv
// Self-checking bench for the gate sequencer and charge-voltage decode.
// Assumes the driver model stands on the gate outputs.
`timescale 1ns/10ps
`default_nettype none

module bgsv_top_tb
  import bgsv_pkg::*;
;
  logic clk, rst, wr, rd, amp, syn, bst, hs, ls, rr, voltage_out_of_range_flag, leak, ovl, seen, ce;
  logic [7:0]  addr;                 // Register address
  logic [15:0] wdat, rdat, d;        // Bus data
  logic [6:0]  code;                 // Per-cell code
  logic [2:0]  cnt;                  // Cell count
  int          err_total, cmp_count, n, c, k, seed;
  logic        v, dis;
  int          vs[$] = '{8999, 9000, 11999, 12000, 14399, 14400, 15999, 16000,
                         19175, 19199, 19200, 30000};

  bgsv_top bgsv_top_inst (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .error_amp_above_i(amp), .sync_current_above_i(syn), .bootstrap_low_i(bst),
    .hs_gate_o(hs), .ls_gate_o(ls), .ramp_reset_o(rr), .cell_code_o(code),
    .cell_count_o(cnt), .voltage_out_of_range_flag_o(voltage_out_of_range_flag));
  bgsv_drv_model bgsv_drv_model_inst (.clk_i(clk), .rst_i(rst), .hs_gate_i(hs),
    .ls_gate_i(ls), .leak_i(leak), .bootstrap_low_o(bst), .overlap_o(ovl));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Value comparison with a count of every check
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] w);
    @(posedge clk);
    addr <= a;
    wdat <= w;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Register read, data taken in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] r);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    r = rdat;
  endtask

  // Count falling edges until a gate or ramp pulse reaches a level
  task automatic wait_for(input int s, input logic lv, output int m);
    m = 0;
    do begin
      @(negedge clk);
      m++;
      seen |= hs | ls;
    end while (((s == 0) ? hs : (s == 1) ? ls : rr) !== lv && m < 1000);
  endtask

  // Reference decode of the charge-voltage setting in mV
  function automatic void dec(input int mv, output int cd, output int cl,
                              output logic fl, output logic off);
    cd = -1; cl = -1; fl = 1'b1; off = 1'b1;
    if (mv == 9000) begin
      cl = 2; fl = 1'b0; off = 1'b0;
    end else if (mv >= 12000 && mv < 14400) begin
      cd = (mv - 12000) * 4 / 75; cl = 3; fl = 1'b0; off = 1'b0;
    end else if (mv >= 16000 && mv < 19200) begin
      cd = (mv - 16000) / 25; cl = 4; fl = 1'b0; off = 1'b0;
    end else if (mv >= 19200) begin
      cd = 127; cl = 4; off = 1'b0;
    end
  endfunction

  // Closing report and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_total = 0; cmp_count = 0; seed = 32'h2fd4; seen = 1'b0;
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdat = 16'h0000;
    amp = 1'b0; syn = 1'b0; leak = 1'b0; ce = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ADDR_MODE, d);
    chk("mode", MODE_RST, d);
    rd_reg(8'h40, d);
    chk("unmapped", 16'h0000, d);
    wr_reg(ADDR_MODE, 16'h0000);
    for (k = 0; k < 8; k++) vs.push_back(int'($unsigned($random(seed)) % 21000));
    // Decode table, boundaries then random settings
    foreach (vs[i]) begin
      wr_reg(ADDR_VREG, 16'(vs[i]));
      repeat (3) @(posedge clk);
      rd_reg(ADDR_STATUS, d);
      dec(vs[i], c, n, v, dis);
      chk("flag", 16'(v), 16'(voltage_out_of_range_flag));
      chk("status range", 16'(v), 16'(d[ST_VOR_B]));
      chk("status off", 16'(dis), 16'(d[ST_DIS_B]));
      if (c >= 0) chk("code", 16'(c), 16'(code));
      if (n >= 0) chk("cells", 16'(n), 16'(cnt));
    end
    wr_reg(ADDR_VREG, 16'd16000);
    // Zero duty at the default rate
    wait_for(2, 1'b1, n);
    seen = 1'b0;
    wait_for(2, 1'b1, n);
    chk("period lo", 16'(PER_LO_CYC), 16'(n));
    chk("no gate", 16'h0000, 16'(seen));
    wr_reg(ADDR_MODE, 16'h0020);
    wait_for(2, 1'b1, n);
    wait_for(2, 1'b1, n);
    chk("period hi", 16'(PER_HI_CYC), 16'(n));
    // Nonsync then sync: short duty, then the low side
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      syn <= k[0];
      amp <= 1'b1;
      wait_for(0, 1'b1, n);
      @(posedge clk);
      amp <= 1'b0;
      wait_for(0, 1'b0, n);
      wait_for(1, 1'b1, n);
      chk("dead", 16'(DEAD_CYC), 16'(n));
      if (k == 0) begin
        wait_for(1, 1'b0, n);
        chk("pulse", 16'(RECH_CYC), 16'(n));
      end
      rd_reg(ADDR_STATUS, d);
      chk("sync bit", 16'(k), 16'(d[ST_SYNC_B]));
      if (k == 1) begin
        @(posedge clk);
        amp <= 1'b1;
        wait_for(1, 1'b0, n);
        chk("ls fill", 16'h0001, 16'(n > RECH_CYC + 8));
        wait_for(0, 1'b1, n);
        chk("dead rise", 16'(DEAD_CYC), 16'(n));
      end
    end
    // Full duty with a sagging bootstrap cap, refresh twice
    @(posedge clk);
    syn <= 1'b0;
    amp <= 1'b1;
    leak <= 1'b1;
    for (k = 0; k < 2; k++) begin
      wait_for(1, 1'b1, n);
      chk("refresh wait", 16'h0001, 16'(n > 3 * PER_HI_CYC && n <= 6 * PER_HI_CYC));
      wait_for(1, 1'b0, n);
      chk("refresh len", 16'(RECH_CYC), 16'(n));
      wait_for(0, 1'b1, n);
      chk("resume", 16'(DEAD_CYC), 16'(n));
    end
    rd_reg(ADDR_STATUS, d);
    chk("refresh seen", 16'h0001, 16'(d[ST_RFSH_B]));
    rd_reg(ADDR_STATUS, d);
    chk("refresh clear", 16'h0000, 16'(d[ST_RFSH_B]));
    // Clock enable low freezes the period counter and gates
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    c = {29'h0, rr, hs, ls};
    seen = 1'b0;
    repeat (200) begin
      @(negedge clk);
      seen |= (c !== {29'h0, rr, hs, ls});
    end
    chk("frozen", 16'h0000, 16'(seen));
    @(posedge clk);
    ce <= 1'b1;
    // A gap setting turns both switches off
    leak <= 1'b0;
    wr_reg(ADDR_VREG, 16'd15000);
    repeat (3) @(negedge clk);
    chk("gates off", 16'h0000, {14'h0000, hs, ls});
    chk("overlap", 16'h0000, 16'(ovl));
    stop_test();
  end
endmodule

`default_nettype wire
